// [verilog/hmt_mode_ctrl.sv]
// operating-mode control registers, trigger handling and fire bit
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - a one written to bit 7 of the mode register aborts playback and returns all registers to defaults.
// - the soft reset bit clears itself when the reset is done, so it reads back zero.
// - bit 6 is software standby, default one; one means standby, zero means ready.
// - mode bits 2-0 default to zero, and in mode 0 only a host write of the fire bit starts a waveform.
// - in mode 1 a rising trigger edge sets the fire bit.
// - in mode 1 a further rising edge while the fire bit is set cancels playback.
// - in mode 2 the fire bit follows the trigger: rising sets it, falling cancels.
// - in mode 2 an edge that matches the fire bit's present state does nothing.
// - in mode 3 the trigger pin is the drive source, treated as PWM or analog by the source select bit.
// - in mode 3 the actuator is driven continuously without the fire bit.
// - in mode 5 the actuator is driven with the real-time playback value.
// - in mode 6 the host fires the test; the device clears fire and records the result flag.
// - in mode 7 the host sets parameters then fires; fire self-clears when calibration ends.
// - the routine result flag holds the last routine's outcome and clears when read.
module hmt_mode_ctrl
	import hmt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic inputTriggerPin,
	input wire logic routineDone,
	input wire logic routineFail,
	input wire logic playbackDone,
	output logic fireOut,
	output logic cancelOut,
	output logic standbyOut,
	output logic [2:0] modeOut,
	output logic driveContinuous,
	output logic driveFromPin,
	output logic srcAnalog,
	output logic acCouplingEnable,
	output logic [7:0] directPlaybackValue,
	output logic softResetOut
);
	logic trigMeta_q, trigSync_q, trigPrev_q;
	logic srst_q, stby_q, fire_q, result_q, cancel_q;
	logic [2:0] mode_q;
	logic [7:0] rtp_q, ctrl_q, rdata_q;
	hmt_srst_t srState_q;
	logic wrMode, wrFire, wrRtp, wrCtrl, rise, fall, clrAll;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return regWrite && (a == b);
	endfunction

	assign wrMode = hit(regAddr, ADDR_MODE);
	assign wrFire = hit(regAddr, ADDR_FIRE);
	assign wrRtp = hit(regAddr, ADDR_RTP);
	assign wrCtrl = hit(regAddr, ADDR_CTRL);
	assign rise = trigSync_q && !trigPrev_q;
	assign fall = !trigSync_q && trigPrev_q;
	assign clrAll = (srState_q == SR_ACTIVE);

	// ------------------------------------------------
	// trigger pin synchroniser
	// ------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigMeta_q <= 1'b0;
			trigSync_q <= 1'b0;
			trigPrev_q <= 1'b0;
		end else begin
			trigMeta_q <= inputTriggerPin;
			trigSync_q <= trigMeta_q;
			trigPrev_q <= trigSync_q;
		end
	end

	// ------------------------------------------------
	// soft reset sequencer
	// ------------------------------------------------
	// one cycle active, then the bit drops on its own
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srState_q <= SR_IDLE;
			srst_q <= 1'b0;
		end else begin
			case (srState_q)
				SR_IDLE: begin
					if (wrMode && regWdata[BIT_SRST]) begin
						srState_q <= SR_ACTIVE;
						srst_q <= 1'b1;
					end
				end
				SR_ACTIVE: begin
					srState_q <= SR_IDLE;
					srst_q <= 1'b0;
				end
				default: begin
					srState_q <= SR_IDLE;
					srst_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// mode, standby, playback value, source control
	// ------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stby_q <= RST_STBY;
			mode_q <= RST_MODE;
			rtp_q <= RST_RTP;
			ctrl_q <= RST_CTRL;
		end else if (clrAll) begin
			stby_q <= RST_STBY;
			mode_q <= RST_MODE;
			rtp_q <= RST_RTP;
			ctrl_q <= RST_CTRL;
		end else begin
			if (wrMode && !regWdata[BIT_SRST]) begin
				stby_q <= regWdata[BIT_STBY];
				mode_q <= regWdata[2:0];
			end
			if (wrRtp)
				rtp_q <= regWdata;
			if (wrCtrl)
				ctrl_q <= regWdata;
		end
	end

	// ------------------------------------------------
	// fire bit and cancel
	// ------------------------------------------------
	// pin edges win over a host clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fire_q <= 1'b0;
			cancel_q <= 1'b0;
		end else begin
			cancel_q <= 1'b0;
			if (clrAll || (wrMode && regWdata[BIT_SRST])) begin
				fire_q <= 1'b0;
				cancel_q <= fire_q;
			end else begin
				case (hmt_mode_t'(mode_q))
					MODE_EDGE: begin
						if (rise && fire_q) begin
							fire_q <= 1'b0;
							cancel_q <= 1'b1;
						end else if (rise)
							fire_q <= 1'b1;
						else if (playbackDone)
							fire_q <= 1'b0;
						else if (wrFire)
							fire_q <= regWdata[BIT_FIRE];
					end
					MODE_LEVEL: begin
						if (rise && !fire_q)
							fire_q <= 1'b1;
						else if (fall && fire_q) begin
							fire_q <= 1'b0;
							cancel_q <= 1'b1;
						end else if (playbackDone)
							fire_q <= 1'b0;
					end
					MODE_DIAG, MODE_CAL: begin
						if (routineDone && fire_q)
							fire_q <= 1'b0;
						else if (wrFire)
							fire_q <= regWdata[BIT_FIRE];
					end
					default: begin
						if (wrFire)
							fire_q <= regWdata[BIT_FIRE];
						else if (playbackDone)
							fire_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------
	// routine result flag and read data
	// ------------------------------------------------
	// a new result arriving with the read is kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			result_q <= 1'b0;
		else if (clrAll)
			result_q <= 1'b0;
		else if (routineDone && fire_q &&
			(mode_q == MODE_DIAG || mode_q == MODE_CAL))
			result_q <= routineFail;
		else if (regRead && regAddr == ADDR_STATUS)
			result_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= 8'h00;
			case (regAddr)
				ADDR_STATUS: rdata_q[BIT_RESULT] <= result_q;
				ADDR_MODE: rdata_q <= {srst_q, stby_q, 3'h0, mode_q};
				ADDR_RTP: rdata_q <= rtp_q;
				ADDR_FIRE: rdata_q[BIT_FIRE] <= fire_q;
				ADDR_CTRL: rdata_q <= ctrl_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------
	// registered outputs
	// ------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 8'h00;
			fireOut <= 1'b0;
			cancelOut <= 1'b0;
			standbyOut <= RST_STBY;
			modeOut <= RST_MODE;
			driveContinuous <= 1'b0;
			driveFromPin <= 1'b0;
			srcAnalog <= 1'b0;
			acCouplingEnable <= 1'b0;
			directPlaybackValue <= RST_RTP;
			softResetOut <= 1'b0;
		end else begin
			regRdata <= rdata_q;
			fireOut <= fire_q;
			cancelOut <= cancel_q;
			standbyOut <= stby_q;
			modeOut <= mode_q;
			driveContinuous <= !stby_q && (mode_q == MODE_PWM_ANALOG ||
				mode_q == MODE_DIRECT);
			driveFromPin <= mode_q == MODE_PWM_ANALOG ||
				mode_q == MODE_AUDIO;
			srcAnalog <= ctrl_q[BIT_SRCSEL];
			acCouplingEnable <= ctrl_q[BIT_ACCPL];
			directPlaybackValue <= rtp_q;
			softResetOut <= srst_q;
		end
	end
endmodule
`default_nettype wire

// [inc/hmt_pkg.sv]
// constants and types for the haptic mode and trigger control block
package hmt_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h01;
	localparam logic [7:0] ADDR_RTP = 8'h02;
	localparam logic [7:0] ADDR_FIRE = 8'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h1D;
	localparam int BIT_SRST = 7;
	localparam int BIT_STBY = 6;
	localparam int BIT_RESULT = 3;
	localparam int BIT_FIRE = 0;
	localparam int BIT_SRCSEL = 5;
	localparam int BIT_ACCPL = 1;
	localparam logic RST_STBY = 1'b1;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [7:0] RST_RTP = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	typedef enum logic [2:0] {
		MODE_INTERNAL, MODE_EDGE, MODE_LEVEL, MODE_PWM_ANALOG,
		MODE_AUDIO, MODE_DIRECT, MODE_DIAG, MODE_CAL
	} hmt_mode_t;
	typedef enum logic [1:0] {
		SR_IDLE, SR_ACTIVE
	} hmt_srst_t;
endpackage

// [verification/hmt_mode_ctrl_props.sv]
// assertions on the ports of the mode control block
`timescale 1ns/10ps
`default_nettype none
module hmt_mode_ctrl_props
	import hmt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic inputTriggerPin,
	input wire logic fireOut,
	input wire logic cancelOut,
	input wire logic standbyOut,
	input wire logic [2:0] modeOut,
	input wire logic driveContinuous,
	input wire logic driveFromPin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_modeWr;
		regWrite && regAddr == ADDR_MODE;
	endsequence
	property p_srst;
		s_modeWr ##0 regWdata[7] |-> ##[1:3] standbyOut && modeOut == 3'h0;
	endproperty
	property p_mode;
		logic [7:0] v;
		(s_modeWr ##0 (!regWdata[7], v = regWdata)) |->
			##2 modeOut == v[2:0] && standbyOut == v[6];
	endproperty
	property p_rsv;
		regRead && regAddr == ADDR_MODE |-> ##2 regRdata[5:3] == 3'h0 &&
			regRdata[2:0] == $past(modeOut) &&
			regRdata[6] == $past(standbyOut);
	endproperty
	property p_fire0;
		$rose(fireOut) && modeOut == MODE_INTERNAL |->
			$past(regWrite && regAddr == ADDR_FIRE && regWdata[0], 2);
	endproperty
	property p_edge;
		$rose(inputTriggerPin) && modeOut == MODE_EDGE && !fireOut |->
			##[2:4] fireOut;
	endproperty
	property p_cancel;
		$rose(inputTriggerPin) && modeOut == MODE_EDGE && fireOut |->
			##[1:4] cancelOut;
	endproperty
	property p_level;
		$fell(inputTriggerPin) && modeOut == MODE_LEVEL && fireOut |->
			##[1:4] cancelOut;
	endproperty
	property p_drive;
		modeOut == MODE_PWM_ANALOG |->
			driveFromPin && (standbyOut || driveContinuous);
	endproperty
	property p_direct;
		modeOut == MODE_DIRECT |->
			!driveFromPin && (standbyOut || driveContinuous);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset no defaults");
	a_mode: assert property (p_mode) else $error("mode write lost");
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	a_fire0: assert property (p_fire0) else $error("fire without write");
	a_edge: assert property (p_edge) else $error("edge did not fire");
	a_cancel: assert property (p_cancel) else $error("no edge cancel");
	a_level: assert property (p_level) else $error("no level cancel");
	a_drive: assert property (p_drive) else $error("pin drive off");
	a_direct: assert property (p_direct) else $error("direct drive off");
endmodule
bind hmt_mode_ctrl hmt_mode_ctrl_props hmt_mode_ctrl_props_inst (.clk, .rst_n,
	.regWrite, .regRead, .regAddr, .regWdata, .regRdata, .inputTriggerPin,
	.fireOut, .cancelOut, .standbyOut, .modeOut, .driveContinuous,
	.driveFromPin);
`default_nettype wire

// [verification/hmt_engine_model.sv]
// stand-in for the playback and routine engines behind the fire bit
`timescale 1ns/10ps
`default_nettype none
module hmt_engine_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fireOut,
	input wire logic [2:0] modeOut,
	input wire logic stall,
	input wire logic failIn,
	output logic routineDone,
	output logic routineFail,
	output logic playbackDone
);
	int cnt;
	logic done;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt <= 0;
		else if (!fireOut) cnt <= 0;
		else if (!stall && cnt < 6) cnt <= cnt + 1;
	end
	assign done = cnt == 5 && !stall;
	assign routineDone = done && modeOut[2:1] == 2'h3;
	assign playbackDone = done && modeOut[2:1] != 2'h3;
	// outcome is only meaningful with done, so show garbage otherwise
	assign routineFail = done ? failIn : ~failIn;
endmodule
`default_nettype wire

// [verification/hmt_mode_ctrl_bench.sv]
// self-checking bench for the mode control block
`timescale 1ns/10ps
`default_nettype none
module hmt_mode_ctrl_bench import hmt_pkg::*;;
	logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0, stall = 0, failIn = 0;
	logic inputTriggerPin = 0, routineDone, routineFail, playbackDone, fireOut;
	logic cancelOut, standbyOut, driveContinuous, driveFromPin;
	logic srcAnalog, acCouplingEnable, softResetOut;
	logic [7:0] regAddr = 0, regWdata = 0, regRdata, directPlaybackValue, d;
	logic [2:0] modeOut;
	int errors = 0, n_checks = 0, seed = 32'hD8BB, i;
	int cancels = 0, resets = 0;
	always #50 clk = ~clk;
	hmt_mode_ctrl hmt_mode_ctrl_inst (.clk, .rst_n, .regWrite, .regRead,
		.regAddr, .regWdata, .regRdata, .inputTriggerPin, .routineDone,
		.routineFail, .playbackDone, .fireOut, .cancelOut, .standbyOut, .modeOut,
		.driveContinuous, .driveFromPin, .srcAnalog, .acCouplingEnable,
		.directPlaybackValue, .softResetOut);
	hmt_engine_model hmt_engine_model_inst (.clk, .rst_n, .fireOut, .modeOut,
		.stall, .failIn, .routineDone, .routineFail, .playbackDone);
	// one-cycle pulses are counted so a later check still sees them
	always @(posedge clk) begin
		if (cancelOut) cancels <= cancels + 1;
		if (softResetOut) resets <= resets + 1;
	end
	// ----------------------------------------
	// bus tasks and checking
	// ----------------------------------------
	task chk(input string nm, input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [7:0] a, v);
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWrite <= 1'h0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'h0;
		@(posedge clk);
		#1 chk("rdata", regRdata, e);
	endtask
	task waitFire(input logic v);
		for (int k = 0; k < 40 && fireOut !== v; k++) begin
			@(posedge clk);
			#1;
		end
		chk("fire", {7'h0, fireOut}, {7'h0, v});
		if (fireOut !== v) stop_test;
	endtask
	task pin(input logic v);
		@(posedge clk);
		inputTriggerPin <= v;
		repeat (6) @(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		rd(ADDR_MODE, 8'h40);
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed)) & 8'h38 | 8'h40 | 8'(i);
			wr(ADDR_MODE, d);
			rd(ADDR_MODE, d & 8'h47);
			chk("mode", {5'h0, modeOut}, 8'(i));
		end
		d = 8'($random(seed));
		wr(ADDR_RTP, d);
		rd(ADDR_RTP, d);
		chk("rtp", directPlaybackValue, d);
		d = 8'(1 << BIT_SRCSEL | 1 << BIT_ACCPL);
		wr(ADDR_CTRL, d);
		wr(ADDR_MODE, 8'h04);
		rd(ADDR_CTRL, d);
		chk("acCouple", {7'h0, acCouplingEnable}, 8'h01);
		chk("analog", {7'h0, srcAnalog}, 8'h01);
		chk("pinDrive", {6'h0, driveFromPin, driveContinuous}, 8'h02);
		wr(ADDR_MODE, 8'h03);
		rd(ADDR_MODE, 8'h03);
		chk("pinDrive", {6'h0, driveFromPin, driveContinuous}, 8'h03);
		wr(ADDR_MODE, 8'h05);
		rd(ADDR_MODE, 8'h05);
		chk("rtpDrive", {6'h0, driveFromPin, driveContinuous}, 8'h01);
		wr(ADDR_MODE, 8'h00);
		stall <= 1'h1;
		wr(ADDR_FIRE, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("fire", {7'h0, fireOut}, 8'h01);
		stall <= 1'h0;
		waitFire(0);
		wr(ADDR_MODE, 8'h01);
		stall <= 1'h1;
		pin(1);
		waitFire(1);
		pin(0);
		pin(1);
		waitFire(0);
		chk("cancel", 8'(cancels), 8'h01);
		pin(0);
		wr(ADDR_MODE, 8'h02);
		pin(1);
		waitFire(1);
		pin(0);
		waitFire(0);
		chk("cancel", 8'(cancels), 8'h02);
		stall <= 1'h0;
		for (i = 6; i < 8; i++) begin
			failIn <= i == 6;
			wr(ADDR_MODE, 8'(i));
			wr(ADDR_FIRE, 8'h01);
			waitFire(1);
			waitFire(0);
			rd(ADDR_STATUS, i == 6 ? 8'h08 : 8'h00);
			rd(ADDR_STATUS, 8'h00);
		end
		wr(ADDR_RTP, 8'h5A);
		wr(ADDR_MODE, 8'h85);
		repeat (3) @(posedge clk);
		rd(ADDR_MODE, 8'h40);
		rd(ADDR_RTP, 8'h00);
		rd(ADDR_CTRL, 8'h00);
		chk("srst", 8'(resets), 8'h01);
		stop_test;
	end
endmodule
`default_nettype wire
